/* pkg/fia_pkg.sv */
// Constants shared by the fair-insertion arbiter and its rate estimator.
// Assumes one 250 MHz clock and an AXI4-Lite master for the status view.
// What this block does
// - Per direction: 32 three-bit counters, one total
// - Reset clears all unit and total counters
// - Forwarded packet bumps its unit and total
// - Unit overflow captures total plus one as divisor, clears
// - Divisor resets to one
// - Local may go when nothing forwarded waits
// - Spread local insertions evenly, no bursts
// - Eight-bit window resets one, priority zero
// - Only forwarded ready: send, decrement window, unless a priority local is credit-blocked on the same VC
// - Only local ready: send, clear priority
// - Both ready: priority picks local, else forwarded
// - Window reaching zero reloads, sets priority
// - Nine-bit LFSR x9+x4+1 steps per reload
// - Reload is (divisor plus LFSR low three)>>3
// - NOP and Sync bypass the fairness logic
// - Independent copy for upstream and downstream
// - No software control, no configurable fairness
// - Candidate needs readiness and far buffer credits
// - Tunnel nodes implement this insertion method
// - Credit counters saturate, at least four bits
package fia_pkg;
	// ----------------------------------------
	// Fairness structure
	// ----------------------------------------
	localparam int NUM_DIR = 2;
	localparam int DIR_UP = 0;
	localparam int DIR_DN = 1;
	localparam int NUM_UNITS = 32;
	localparam int UNIT_W = 5;
	localparam int UNIT_CNT_W = 3;
	localparam int TOTAL_W = 8;
	localparam int WIN_W = 8;
	localparam int LFSR_W = 9;
	localparam int LFSR_TAP_HI = 8;
	localparam int LFSR_TAP_LO = 3;
	localparam int RELOAD_SHIFT = 3;
	localparam logic [2:0] UNIT_CNT_MAX = 3'h7;
	localparam logic [7:0] TOTAL_RST = 8'h00;
	localparam logic [7:0] DIV_RST = 8'h01;
	localparam logic [7:0] WIN_RST = 8'h01;
	localparam logic [8:0] LFSR_RST = 9'h001;
	// ----------------------------------------
	// Virtual channels and credits
	// ----------------------------------------
	localparam int NUM_VC = 3;
	localparam int VC_W = 2;
	localparam int REL_W = 2;
	localparam int CRED_W = 4;
	localparam logic [1:0] VC_POSTED = 2'h0;
	localparam logic [1:0] VC_NONPOSTED = 2'h1;
	localparam logic [1:0] VC_RESPONSE = 2'h2;
	// ----------------------------------------
	// Status register map (read only)
	// ----------------------------------------
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFS_DIV_UP = 8'h00;
	localparam logic [7:0] OFS_DIV_DN = 8'h04;
	localparam logic [7:0] OFS_WIN_UP = 8'h08;
	localparam logic [7:0] OFS_WIN_DN = 8'h0c;
	localparam logic [7:0] OFS_CRED = 8'h10;
	localparam int STAT_PRIO_BIT = 8;
	localparam int STAT_LFSR_LSB = 16;
	localparam int CRED_FIELD_W = 4;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	function automatic logic [LFSR_W-1:0] lfsr_step(input logic [LFSR_W-1:0] cur);
		return {cur[LFSR_W-2:0], cur[LFSR_TAP_HI] ^ cur[LFSR_TAP_LO]};
	endfunction : lfsr_step
endpackage : fia_pkg

/* verilog/fia_rate_est.sv */
// Forwarding-rate estimator for one direction: per-unit counters and divisor.
// Assumes fwdSent pulses once per forwarded packet with its source unit.
`timescale 1ns/1ns
module fia_rate_est (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Forwarded packet event
	input wire logic fwdSent,
	input wire logic [fia_pkg::UNIT_W-1:0] fwdSrcUnit,
	// Captured divisor
	output logic [fia_pkg::TOTAL_W-1:0] divisor
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic [fia_pkg::NUM_UNITS-1:0][fia_pkg::UNIT_CNT_W-1:0] unitCnt;
		logic [fia_pkg::TOTAL_W-1:0] total;
		logic [fia_pkg::TOTAL_W-1:0] div;
	} fia_est_st_t;

	fia_est_st_t st_r;
	fia_est_st_t st_nxt;

	assign divisor = st_r.div;

	// ----------------------------------------
	// Counting
	// ----------------------------------------
	always_comb begin
		st_nxt = st_r;
		if (fwdSent) begin
			if (st_r.unitCnt[fwdSrcUnit] == fia_pkg::UNIT_CNT_MAX) begin
				st_nxt.div = st_r.total + 8'h01;
				st_nxt.unitCnt = '0;
				st_nxt.total = fia_pkg::TOTAL_RST;
			end else begin
				st_nxt.unitCnt[fwdSrcUnit] = st_r.unitCnt[fwdSrcUnit] + 3'h1;
				st_nxt.total = st_r.total + 8'h01;
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			st_r.unitCnt <= '0;
			st_r.total <= fia_pkg::TOTAL_RST;
			st_r.div <= fia_pkg::DIV_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_div_capture: assert property (@(posedge clk) disable iff (!arst_n)
		fwdSent && st_r.unitCnt[fwdSrcUnit] == fia_pkg::UNIT_CNT_MAX
		|=> divisor == $past(st_r.total) + 8'h01 && st_r.total == 8'h00 && st_r.unitCnt == '0)
		else $error("divisor not captured on unit overflow");
	a_total_count: assert property (@(posedge clk) disable iff (!arst_n)
		fwdSent && st_r.unitCnt[fwdSrcUnit] != fia_pkg::UNIT_CNT_MAX
		|=> st_r.total == $past(st_r.total) + 8'h01 && $stable(divisor))
		else $error("total counter did not advance");
	a_total_idle: assert property (@(posedge clk) disable iff (!arst_n)
		!fwdSent |=> $stable(st_r.total) && $stable(divisor))
		else $error("counters moved without a forwarded packet");
endmodule : fia_rate_est

/* verilog/fia_fair_arb.sv */
// Two-direction fair-insertion arbiter with credit gating and status view.
// Assumes candidates hold valid until their take pulse; info packets are NOP/Sync.
`timescale 1ns/1ns
module fia_fair_arb #(
	parameter int CRED_W = fia_pkg::CRED_W
) (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Forwarded candidates, index 0 upstream, 1 downstream
	input wire logic [fia_pkg::NUM_DIR-1:0] fwdValid,
	input wire logic [fia_pkg::NUM_DIR-1:0][fia_pkg::UNIT_W-1:0] fwdSrcUnit,
	input wire logic [fia_pkg::NUM_DIR-1:0][fia_pkg::VC_W-1:0] fwdVc,
	// Local candidates
	input wire logic [fia_pkg::NUM_DIR-1:0] locValid,
	input wire logic [fia_pkg::NUM_DIR-1:0][fia_pkg::VC_W-1:0] locVc,
	// Per-link info packets
	input wire logic [fia_pkg::NUM_DIR-1:0] infoValid,
	// Buffer releases from the far receiver
	input wire logic [fia_pkg::NUM_DIR-1:0][fia_pkg::NUM_VC-1:0][fia_pkg::REL_W-1:0] credRel,
	// Grants
	output logic [fia_pkg::NUM_DIR-1:0] fwdTake,
	output logic [fia_pkg::NUM_DIR-1:0] locTake,
	output logic [fia_pkg::NUM_DIR-1:0] infoTake,
	// AXI4-Lite write
	input wire logic [fia_pkg::ADDR_W-1:0] s_axil_awaddr,
	input wire logic s_axil_awvalid,
	output logic s_axil_awready,
	input wire logic [31:0] s_axil_wdata,
	input wire logic [3:0] s_axil_wstrb,
	input wire logic s_axil_wvalid,
	output logic s_axil_wready,
	output logic [1:0] s_axil_bresp,
	output logic s_axil_bvalid,
	input wire logic s_axil_bready,
	// AXI4-Lite read
	input wire logic [fia_pkg::ADDR_W-1:0] s_axil_araddr,
	input wire logic s_axil_arvalid,
	output logic s_axil_arready,
	output logic [31:0] s_axil_rdata,
	output logic [1:0] s_axil_rresp,
	output logic s_axil_rvalid,
	input wire logic s_axil_rready
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic [fia_pkg::NUM_DIR-1:0][fia_pkg::WIN_W-1:0] win;
		logic [fia_pkg::NUM_DIR-1:0] prio;
		logic [fia_pkg::NUM_DIR-1:0][fia_pkg::LFSR_W-1:0] lfsr;
		logic [fia_pkg::NUM_DIR-1:0][fia_pkg::NUM_VC-1:0][CRED_W-1:0] cred;
		logic [fia_pkg::NUM_DIR-1:0] fwdTake;
		logic [fia_pkg::NUM_DIR-1:0] locTake;
		logic [fia_pkg::NUM_DIR-1:0] infoTake;
		logic awSeen;
		logic wSeen;
		logic [fia_pkg::ADDR_W-1:0] awAddr;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} fia_arb_st_t;

	fia_arb_st_t st_r;
	fia_arb_st_t st_nxt;

	logic [fia_pkg::NUM_DIR-1:0][fia_pkg::TOTAL_W-1:0] divisor;
	logic [fia_pkg::NUM_DIR-1:0] busy;
	logic [fia_pkg::NUM_DIR-1:0] fwdRdy;
	logic [fia_pkg::NUM_DIR-1:0] locRdy;
	logic [fia_pkg::NUM_DIR-1:0] holdFwd;
	logic [fia_pkg::NUM_DIR-1:0] sendInfo;
	logic [fia_pkg::NUM_DIR-1:0] sendLoc;
	logic [fia_pkg::NUM_DIR-1:0] sendFwd;

	assign fwdTake = st_r.fwdTake;
	assign locTake = st_r.locTake;
	assign infoTake = st_r.infoTake;
	assign s_axil_awready = st_r.awready;
	assign s_axil_wready = st_r.wready;
	assign s_axil_bvalid = st_r.bvalid;
	assign s_axil_bresp = st_r.bresp;
	assign s_axil_arready = st_r.arready;
	assign s_axil_rvalid = st_r.rvalid;
	assign s_axil_rdata = st_r.rdata;
	assign s_axil_rresp = st_r.rresp;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Credits saturate rather than wrap, so extra releases are dropped
	function automatic logic [CRED_W-1:0] credNext(input logic [CRED_W-1:0] cur,
			input logic [fia_pkg::REL_W-1:0] rel, input logic used);
		logic [CRED_W:0] sum;
		sum = {1'b0, cur} - (CRED_W+1)'(used) + (CRED_W+1)'(rel);
		return sum[CRED_W] ? {CRED_W{1'b1}} : sum[CRED_W-1:0];
	endfunction : credNext

	function automatic logic [fia_pkg::WIN_W-1:0] reloadVal(input logic [fia_pkg::TOTAL_W-1:0] div,
			input logic [fia_pkg::LFSR_W-1:0] lfsr);
		logic [fia_pkg::TOTAL_W:0] sum;
		sum = {1'b0, div} + (fia_pkg::TOTAL_W+1)'(lfsr[2:0]);
		return fia_pkg::WIN_W'(sum >> fia_pkg::RELOAD_SHIFT);
	endfunction : reloadVal

	function automatic logic credOk(input logic [fia_pkg::NUM_VC-1:0][CRED_W-1:0] cred,
			input logic [fia_pkg::VC_W-1:0] vc);
		return (vc < fia_pkg::VC_W'(fia_pkg::NUM_VC)) && (cred[vc] != '0);
	endfunction : credOk

	function automatic logic isMapped(input logic [fia_pkg::ADDR_W-1:0] addr);
		logic [fia_pkg::ADDR_W-1:0] wa;
		wa = {addr[fia_pkg::ADDR_W-1:2], 2'b00};
		return wa == fia_pkg::OFS_DIV_UP || wa == fia_pkg::OFS_DIV_DN || wa == fia_pkg::OFS_WIN_UP
			|| wa == fia_pkg::OFS_WIN_DN || wa == fia_pkg::OFS_CRED;
	endfunction : isMapped

	function automatic logic [31:0] winStatus(input logic [fia_pkg::WIN_W-1:0] win, input logic prio,
			input logic [fia_pkg::LFSR_W-1:0] lfsr);
		logic [31:0] v;
		v = '0;
		v[fia_pkg::WIN_W-1:0] = win;
		v[fia_pkg::STAT_PRIO_BIT] = prio;
		v[fia_pkg::STAT_LFSR_LSB +: fia_pkg::LFSR_W] = lfsr;
		return v;
	endfunction : winStatus

	// ----------------------------------------
	// Rate estimators, one per direction
	// ----------------------------------------
	generate
		for (genvar gd = 0; gd < fia_pkg::NUM_DIR; gd++) begin : g_est
			fia_rate_est u_est (
				.clk(clk),
				.arst_n(arst_n),
				.fwdSent(sendFwd[gd]),
				.fwdSrcUnit(fwdSrcUnit[gd]),
				.divisor(divisor[gd])
			);
		end
	endgenerate

	// ----------------------------------------
	// Candidate selection
	// ----------------------------------------
	// A take pulse blocks the next cycle so a held valid is never granted twice
	always_comb begin
		for (int d = 0; d < fia_pkg::NUM_DIR; d++) begin
			busy[d] = st_r.fwdTake[d] | st_r.locTake[d] | st_r.infoTake[d];
			fwdRdy[d] = fwdValid[d] && credOk(st_r.cred[d], fwdVc[d]);
			locRdy[d] = locValid[d] && credOk(st_r.cred[d], locVc[d]);
			holdFwd[d] = st_r.prio[d] && locValid[d] && !locRdy[d] && fwdVc[d] == locVc[d];
			sendInfo[d] = !busy[d] && infoValid[d];
			sendLoc[d] = !busy[d] && !infoValid[d] && locRdy[d] && (!fwdRdy[d] || st_r.prio[d]);
			sendFwd[d] = !busy[d] && !infoValid[d] && fwdRdy[d] && !sendLoc[d] && !holdFwd[d];
		end
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		st_nxt = st_r;
		// Window, priority and LFSR per direction
		for (int d = 0; d < fia_pkg::NUM_DIR; d++) begin
			st_nxt.fwdTake[d] = sendFwd[d];
			st_nxt.locTake[d] = sendLoc[d];
			st_nxt.infoTake[d] = sendInfo[d];
			for (int v = 0; v < fia_pkg::NUM_VC; v++) begin
				st_nxt.cred[d][v] = credNext(st_r.cred[d][v], credRel[d][v],
					(sendFwd[d] && fwdVc[d] == fia_pkg::VC_W'(v))
					|| (sendLoc[d] && locVc[d] == fia_pkg::VC_W'(v)));
			end
			if (sendFwd[d]) begin
				if (st_r.win[d] == fia_pkg::WIN_W'(1)) begin
					// Random low bits give fractional insertion rates, pacing evenly
					st_nxt.win[d] = reloadVal(divisor[d], st_r.lfsr[d]);
					st_nxt.prio[d] = 1'b1;
					st_nxt.lfsr[d] = fia_pkg::lfsr_step(st_r.lfsr[d]);
				end else begin
					st_nxt.win[d] = st_r.win[d] - fia_pkg::WIN_W'(1);
				end
			end
			if (sendLoc[d]) begin
				st_nxt.prio[d] = 1'b0;
			end
		end
		// Write channel: no writable fields, every write is refused
		if (s_axil_awvalid && st_r.awready) begin
			st_nxt.awSeen = 1'b1;
			st_nxt.awAddr = s_axil_awaddr;
		end
		if (s_axil_wvalid && st_r.wready) begin
			st_nxt.wSeen = 1'b1;
		end
		if (st_r.bvalid && s_axil_bready) begin
			st_nxt.bvalid = 1'b0;
		end else if (st_r.awSeen && st_r.wSeen && !st_r.bvalid) begin
			st_nxt.bvalid = 1'b1;
			st_nxt.bresp = isMapped(st_r.awAddr) ? fia_pkg::RESP_SLVERR : fia_pkg::RESP_DECERR;
			st_nxt.awSeen = 1'b0;
			st_nxt.wSeen = 1'b0;
		end
		st_nxt.awready = !st_nxt.awSeen && !st_nxt.bvalid;
		st_nxt.wready = !st_nxt.wSeen && !st_nxt.bvalid;
		// Read channel: observation only
		if (st_r.rvalid && s_axil_rready) begin
			st_nxt.rvalid = 1'b0;
		end else if (s_axil_arvalid && st_r.arready) begin
			st_nxt.rvalid = 1'b1;
			st_nxt.rresp = isMapped(s_axil_araddr) ? fia_pkg::RESP_OKAY : fia_pkg::RESP_DECERR;
			case ({s_axil_araddr[fia_pkg::ADDR_W-1:2], 2'b00})
				fia_pkg::OFS_DIV_UP: st_nxt.rdata = 32'(divisor[fia_pkg::DIR_UP]);
				fia_pkg::OFS_DIV_DN: st_nxt.rdata = 32'(divisor[fia_pkg::DIR_DN]);
				fia_pkg::OFS_WIN_UP: st_nxt.rdata = winStatus(st_r.win[fia_pkg::DIR_UP],
					st_r.prio[fia_pkg::DIR_UP], st_r.lfsr[fia_pkg::DIR_UP]);
				fia_pkg::OFS_WIN_DN: st_nxt.rdata = winStatus(st_r.win[fia_pkg::DIR_DN],
					st_r.prio[fia_pkg::DIR_DN], st_r.lfsr[fia_pkg::DIR_DN]);
				fia_pkg::OFS_CRED: begin
					st_nxt.rdata = '0;
					for (int d = 0; d < fia_pkg::NUM_DIR; d++) begin
						for (int v = 0; v < fia_pkg::NUM_VC; v++) begin
							st_nxt.rdata[(d*fia_pkg::NUM_VC+v)*fia_pkg::CRED_FIELD_W +: fia_pkg::CRED_FIELD_W] =
								fia_pkg::CRED_FIELD_W'(st_r.cred[d][v]);
						end
					end
				end
				default: st_nxt.rdata = '0;
			endcase
		end
		st_nxt.arready = !st_nxt.rvalid;
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			for (int d = 0; d < fia_pkg::NUM_DIR; d++) begin
				st_r.win[d] <= fia_pkg::WIN_RST;
				st_r.lfsr[d] <= fia_pkg::LFSR_RST;
			end
			st_r.prio <= '0;
			st_r.cred <= '0;
			st_r.fwdTake <= '0;
			st_r.locTake <= '0;
			st_r.infoTake <= '0;
			st_r.awSeen <= 1'b0;
			st_r.wSeen <= 1'b0;
			st_r.awAddr <= '0;
			st_r.awready <= 1'b1;
			st_r.wready <= 1'b1;
			st_r.bvalid <= 1'b0;
			st_r.bresp <= fia_pkg::RESP_OKAY;
			st_r.arready <= 1'b1;
			st_r.rvalid <= 1'b0;
			st_r.rdata <= '0;
			st_r.rresp <= fia_pkg::RESP_OKAY;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	generate
		for (genvar gd = 0; gd < fia_pkg::NUM_DIR; gd++) begin : g_chk
			a_one_grant: assert property (@(posedge clk) disable iff (!arst_n)
				$onehot0({fwdTake[gd], locTake[gd], infoTake[gd]}))
				else $error("more than one grant in a cycle");
			a_grant_gap: assert property (@(posedge clk) disable iff (!arst_n)
				(fwdTake[gd] || locTake[gd] || infoTake[gd])
				|=> !(fwdTake[gd] || locTake[gd] || infoTake[gd]))
				else $error("grants back to back");
			a_reload_prio: assert property (@(posedge clk) disable iff (!arst_n)
				sendFwd[gd] && st_r.win[gd] == 8'h01
				|=> st_r.prio[gd] && fwdTake[gd] && st_r.lfsr[gd] != $past(st_r.lfsr[gd]))
				else $error("window reload did not set priority");
			a_local_first: assert property (@(posedge clk) disable iff (!arst_n)
				!busy[gd] && !infoValid[gd] && st_r.prio[gd] && locRdy[gd]
				|=> locTake[gd] && !st_r.prio[gd])
				else $error("priority local packet not sent");
			a_credit_gate: assert property (@(posedge clk) disable iff (!arst_n)
				fwdTake[gd] |-> $past(st_r.cred[gd][fwdVc[gd]]) != '0)
				else $error("forwarded packet sent without credit");
			a_info_bypass: assert property (@(posedge clk) disable iff (!arst_n)
				!busy[gd] && infoValid[gd] |=> infoTake[gd])
				else $error("info packet held back");
			a_lfsr_live: assert property (@(posedge clk) disable iff (!arst_n)
				st_r.lfsr[gd] != '0)
				else $error("shift register reached zero");
			a_starve_hold: assert property (@(posedge clk) disable iff (!arst_n)
				holdFwd[gd] && !busy[gd] |=> !fwdTake[gd] && st_r.prio[gd])
				else $error("blocked channel lost its priority");
		end
	endgenerate

	a_b_hold: assert property (@(posedge clk) disable iff (!arst_n)
		s_axil_bvalid && !s_axil_bready |=> s_axil_bvalid && $stable(s_axil_bresp))
		else $error("write response dropped before taken");
	a_r_hold: assert property (@(posedge clk) disable iff (!arst_n)
		s_axil_rvalid && !s_axil_rready |=> s_axil_rvalid && $stable(s_axil_rdata))
		else $error("read data dropped before taken");
endmodule : fia_fair_arb

/* dv/fia_far_rx.sv */
// Far receiver model: hands buffer credits back per direction and channel.
// Assumes the bench opens or shuts each channel through relMask.
`timescale 1ns/1ns
module fia_far_rx (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Release control
	input wire logic [1:0][2:0] relMask,
	// Credit returns
	output logic [fia_pkg::NUM_DIR-1:0][fia_pkg::NUM_VC-1:0][fia_pkg::REL_W-1:0] credRel
);
	// Three is the most one release field carries, so saturation is reached fast
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			credRel <= '0;
		end else begin
			for (int d = 0; d < fia_pkg::NUM_DIR; d++) begin
				for (int v = 0; v < fia_pkg::NUM_VC; v++) begin
					credRel[d][v] <= relMask[d][v] ? 2'h3 : 2'h0;
				end
			end
		end
	end
endmodule : fia_far_rx

/* dv/link_fair_insertion_arbiter_bench.sv */
// Bench for the fair-insertion arbiter: cycle model of both directions.
// Assumes fia_far_rx returns credits; status is read over AXI4-Lite.
`timescale 1ns/1ns
module link_fair_insertion_arbiter_bench;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic [1:0] fwdValid, locValid, infoValid, fwdTake, locTake, infoTake;
	logic [1:0][4:0] fwdSrcUnit;
	logic [1:0][1:0] fwdVc, locVc;
	logic [1:0][2:0][1:0] credRel;
	logic [1:0][2:0] relMask;
	logic [7:0] awaddr, araddr;
	logic awvalid, wvalid, bvalid, bready, arvalid, rvalid, rready, awready, wready, arready;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic randOn;
	logic [31:0] seed = 32'h000143da;
	int n_errors = 0;
	int checked = 0;
	// Model state, one copy per direction
	logic [2:0] uc[2][32];
	logic [7:0] tot[2], dv[2], win[2];
	logic pr[2];
	logic [8:0] lf[2];
	logic [3:0] cr[2][3];
	logic [2:0] ex[2];
	logic [2:0] g;
	logic [4:0] c;
	logic [31:0] rdv;
	logic [1:0] rsp;

	always #2 clk = ~clk;

	fia_far_rx far (.clk(clk), .arst_n(arst_n), .relMask(relMask), .credRel(credRel));
	fia_fair_arb uut (.clk(clk), .arst_n(arst_n), .fwdValid(fwdValid), .fwdSrcUnit(fwdSrcUnit), .fwdVc(fwdVc),
		.locValid(locValid), .locVc(locVc), .infoValid(infoValid), .credRel(credRel), .fwdTake(fwdTake),
		.locTake(locTake), .infoTake(infoTake), .s_axil_awaddr(awaddr), .s_axil_awvalid(awvalid),
		.s_axil_awready(awready), .s_axil_wdata(32'h0000a5a5), .s_axil_wstrb(4'hf), .s_axil_wvalid(wvalid),
		.s_axil_wready(wready), .s_axil_bresp(bresp), .s_axil_bvalid(bvalid), .s_axil_bready(bready),
		.s_axil_araddr(araddr), .s_axil_arvalid(arvalid), .s_axil_arready(arready), .s_axil_rdata(rdata),
		.s_axil_rresp(rresp), .s_axil_rvalid(rvalid), .s_axil_rready(rready));

	// ----------------------------------------
	// Checking and bus tasks
	// ----------------------------------------
	function automatic logic [31:0] nextRnd(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : nextRnd

	function automatic logic [2:0] pick(input logic fv, lv, iv, fo, lo, p, input logic [1:0] fc, lc);
		if (iv) return 3'h1;
		if (lo && (!fo || p)) return 3'h2;
		// A credit-starved local with priority holds back its own channel only
		if (fo && !(p && lv && !lo && lc == fc)) return 3'h4;
		return 3'h0;
	endfunction : pick

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic rdChk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge clk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		while (rvalid !== 1'b1) @(posedge clk);
		rdv = rdata;
		rsp = rresp;
		rready <= 1'b0;
		chk(rdv, e);
		chk({30'h0, rsp}, {30'h0, er});
	endtask : rdChk

	task automatic wrChk(input logic [7:0] a, input logic [1:0] er);
		@(posedge clk);
		awaddr <= a;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		rsp = bresp;
		bready <= 1'b0;
		chk({30'h0, rsp}, {30'h0, er});
	endtask : wrChk

	task automatic summarize();
		$display("Comparisons %0d, mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : summarize

	// ----------------------------------------
	// Cycle model of grants, credits, window and estimator
	// ----------------------------------------
	always @(posedge clk or negedge arst_n) begin
		for (int d = 0; d < 2; d++) begin
			if (!arst_n) begin
				for (int u = 0; u < 32; u++) uc[d][u] = 3'h0;
				for (int v = 0; v < 3; v++) cr[d][v] = 4'h0;
				{tot[d], dv[d], win[d], pr[d], lf[d], ex[d]} = {8'h00, 8'h01, 8'h01, 1'b0, 9'h001, 3'h0};
			end else begin
				chk({29'h0, fwdTake[d], locTake[d], infoTake[d]}, {29'h0, ex[d]});
				g = (ex[d] != 3'h0) ? 3'h0 : pick(fwdValid[d], locValid[d], infoValid[d],
					fwdValid[d] && fwdVc[d] != 2'h3 && cr[d][fwdVc[d]] != 4'h0,
					locValid[d] && locVc[d] != 2'h3 && cr[d][locVc[d]] != 4'h0, pr[d], fwdVc[d], locVc[d]);
				for (int v = 0; v < 3; v++) begin
					c = {1'b0, cr[d][v]} + credRel[d][v] - ((g[2] && fwdVc[d] == v) || (g[1] && locVc[d] == v));
					cr[d][v] = (c > 5'h0f) ? 4'hf : c[3:0];
				end
				if (g[1]) pr[d] = 1'b0;
				if (g[2]) begin
					// Reload sees the divisor held before this packet is counted
					win[d] = win[d] - 8'h01;
					if (win[d] == 8'h00) begin
						win[d] = 8'(({1'b0, dv[d]} + lf[d][2:0]) >> 3);
						lf[d] = {lf[d][7:0], lf[d][8] ^ lf[d][3]};
						pr[d] = 1'b1;
					end
					if (uc[d][fwdSrcUnit[d]] == 3'h7) begin
						dv[d] = tot[d] + 8'h01;
						tot[d] = 8'h00;
						for (int u = 0; u < 32; u++) uc[d][u] = 3'h0;
					end else begin
						uc[d][fwdSrcUnit[d]] = uc[d][fwdSrcUnit[d]] + 3'h1;
						tot[d] = tot[d] + 8'h01;
					end
				end
				ex[d] = g;
			end
		end
	end

	// ----------------------------------------
	// Candidate sources: drop or renew on each take
	// ----------------------------------------
	always @(posedge clk) begin
		for (int d = 0; d < 2; d++) begin
			if (arst_n && (fwdTake[d] || locTake[d] || infoTake[d])) begin
				if (randOn) begin
					seed = nextRnd(seed);
					infoValid[d] <= (seed[2:0] == 3'h0);
					locValid[d] <= seed[3];
					fwdValid[d] <= seed[4] | seed[5] | ~seed[3];
					fwdVc[d] <= (seed[7:6] == 2'h3) ? 2'h0 : seed[7:6];
					locVc[d] <= (seed[9:8] == 2'h3) ? 2'h1 : seed[9:8];
					fwdSrcUnit[d] <= seed[14:10] & (d ? 5'h03 : 5'h07);
				end else begin
					if (fwdTake[d]) fwdValid[d] <= 1'b0;
					if (locTake[d]) locValid[d] <= 1'b0;
					if (infoTake[d]) infoValid[d] <= 1'b0;
				end
			end
		end
	end

	initial begin
		#100000;
		n_errors++;
		summarize();
	end

	initial begin
		{fwdValid, locValid, infoValid, fwdSrcUnit, fwdVc, locVc, relMask, randOn} = '0;
		{awaddr, araddr, awvalid, wvalid, bready, arvalid, rready} = '0;
		repeat (5) @(posedge clk);
		arst_n <= 1'b1;
		rdChk(8'h00, 32'h00000001, 2'h0);
		rdChk(8'h04, 32'h00000001, 2'h0);
		rdChk(8'h08, 32'h00010001, 2'h0);
		rdChk(8'h0c, 32'h00010001, 2'h0);
		rdChk(8'h10, 32'h00000000, 2'h0);
		rdChk(8'h40, 32'h00000000, 2'h3);
		wrChk(8'h00, 2'h2);
		wrChk(8'h44, 2'h3);
		rdChk(8'h00, 32'h00000001, 2'h0);
		// No credits yet: only the info packets may leave
		fwdValid <= 2'h3;
		locValid <= 2'h3;
		locVc <= {2'h1, 2'h1};
		repeat (16) @(posedge clk);
		infoValid <= 2'h3;
		repeat (8) @(posedge clk);
		relMask <= {3'h1, 3'h1};
		repeat (10) @(posedge clk);
		fwdValid <= 2'h3;
		repeat (10) @(posedge clk);
		relMask <= {3'h7, 3'h7};
		repeat (30) @(posedge clk);
		rdChk(8'h10, 32'h00ffffff, 2'h0);
		randOn <= 1'b1;
		fwdValid <= 2'h3;
		repeat (3000) @(posedge clk);
		randOn <= 1'b0;
		repeat (40) @(posedge clk);
		rdChk(8'h00, {24'h0, dv[0]}, 2'h0);
		rdChk(8'h04, {24'h0, dv[1]}, 2'h0);
		rdChk(8'h08, {7'h0, lf[0], 7'h0, pr[0], win[0]}, 2'h0);
		rdChk(8'h0c, {7'h0, lf[1], 7'h0, pr[1], win[1]}, 2'h0);
		// Second reset in mid-run, then eight packets of one unit
		arst_n <= 1'b0;
		{fwdValid, locValid, infoValid, fwdSrcUnit} <= '0;
		repeat (5) @(posedge clk);
		arst_n <= 1'b1;
		rdChk(8'h00, 32'h00000001, 2'h0);
		repeat (8) begin
			@(posedge clk);
			fwdValid <= 2'h1;
			repeat (12) @(posedge clk);
		end
		rdChk(8'h00, 32'h00000008, 2'h0);
		summarize();
	end
endmodule : link_fair_insertion_arbiter_bench
